// ===== hdl/pat_pkg.sv
// constants shared by the proximity and ambient tracker
// assumes one 125 MHz clock and a converter that delivers one tagged result per stage
// What this block does
// RULE1 - proximity is set when the approach or the hover comparator fires
// RULE2 - approach fires when |fast tap 1 - fast tap 3| exceeds rate level times 16
// RULE3 - hover fires when |fast average - ambient| exceeds hover level times 16
// RULE4 - the approach comparator catches both arrival and departure of a user
// RULE5 - the hover comparator also catches ambient shifts left by moisture or dirt
// RULE6 - fast queue decimator drops that many samples before each fast push
// RULE7 - fast push period is (decimator + 1) times base period times sequence length
// RULE8 - host sets the decimator once, zero when all eight stages run
// RULE9 - ambient gate set only when slow tap 0 - tap 1 exceeds level, no proximity
// RULE10 - third comparator drives the gate; ambient updates only with gate and no proximity, apart from the first result and forced recal
// RULE11 - compensation runs on each gated conversion while the sensor is untouched and outside the hold-off
// RULE12 - ambient comes from samples taken with no approach or touch, except the first result and the fast average of a forced recal
// RULE13 - ambient drift is corrected by rewriting per-stage upper and lower trip levels
// RULE14 - trip levels are sensitivity percentages of swing estimates around ambient
// RULE15 - host alert rises when a result crosses its upper or lower trip level
// RULE16 - per-stage compensation data lives in on-chip memory read and updated here
// RULE17 - full power: calibration stays off hold count times 16 sequences after proximity
// RULE18 - low power: calibration stays off hold count times 4 sequences after proximity
// RULE19 - hover lasting the recal timeout in sequences forces an ambient recalibration
// RULE20 - proximity and hover flags are evaluated per stage, once per sample entering the queue
// RULE21 - proximity freezes ambient and trip levels of its stage, except forced recal
package pat_pkg;
  localparam int STAGES = 8;
  localparam int DW     = 16;
  localparam int AW     = 10;
  localparam int FAST_DEPTH = 4;

  localparam logic [AW-1:0] ADDR_TIMING = 10'h002;
  localparam logic [AW-1:0] ADDR_LEVEL  = 10'h003;
  localparam logic [AW-1:0] ADDR_RECAL  = 10'h004;

  localparam logic [DW-1:0] TIMING_RST = 16'h0000;
  localparam logic [DW-1:0] LEVEL_RST  = 16'h0000;
  localparam logic [DW-1:0] RECAL_RST  = 16'h0000;

  localparam int DEC_LSB      = 0;
  localparam int DEC_W        = 4;
  localparam int FP_HOLD_LSB  = 4;
  localparam int LP_HOLD_LSB  = 8;
  localparam int HOLD_W       = 4;
  localparam int HOVER_LSB    = 0;
  localparam int HOVER_W      = 8;
  localparam int RATE_LSB     = 8;
  localparam int RATE_W       = 6;
  localparam int UPD_LSB      = 14;
  localparam int UPD_W        = 2;
  localparam int FP_RECAL_LSB = 0;
  localparam int FP_RECAL_W   = 10;
  localparam int LP_RECAL_LSB = 10;
  localparam int LP_RECAL_W   = 6;

  // rate and hover levels count in steps of 16 codes, the update level in single codes, hold counts in 16 or 4 sequences
  localparam int LEVEL_SHIFT   = 4;
  localparam int FP_HOLD_SHIFT = 4;
  localparam int LP_HOLD_SHIFT = 2;
  localparam int HOLD_CNT_W    = HOLD_W + FP_HOLD_SHIFT;

  // sensitivity code n gives (16 + 3n)/64: 25 % up to about 95 %
  localparam int SENS_W     = 4;
  localparam int SENS_BASE  = 16;
  localparam int SENS_STEP  = 3;
  localparam int SENS_SHIFT = 6;

  // ambient moves 1/8 of the error per accepted slow sample
  localparam int AMB_SHIFT = 3;
endpackage

// ===== hdl/pat_diff_cmp.sv
// absolute-difference comparator used for the three proximity comparators
// assumes unsigned operands of equal width
`timescale 1ns/1ps
`default_nettype none
module pat_diff_cmp #(
  parameter int DW = 16
) (
  input  wire logic [DW-1:0] a_i,
  input  wire logic [DW-1:0] b_i,
  input  wire logic [DW-1:0] limit_i,
  output logic               over_o
);
  wire [DW-1:0] diff = (a_i >= b_i) ? (a_i - b_i) : (b_i - a_i);

  assign over_o = diff > limit_i;
endmodule
`default_nettype wire

// ===== hdl/pat_tracker.sv
// per-stage proximity detection and ambient compensation
// assumes converter results arrive tagged with their stage, on clk_sys_i,
// and seq_done_i pulses once at the end of every conversion sequence
`timescale 1ns/1ps
`default_nettype none
module pat_tracker #(
  parameter int STAGES = pat_pkg::STAGES,
  parameter int DW     = pat_pkg::DW
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      reset_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire logic [pat_pkg::AW-1:0]    reg_addr_i,
  input  wire logic [DW-1:0]             reg_wdata_i,
  output logic      [DW-1:0]             reg_rdata_o,
  input  wire logic                      sample_valid_i,
  input  wire logic [$clog2(STAGES)-1:0] sample_stage_i,
  input  wire logic [DW-1:0]             sample_data_i,
  input  wire logic                      seq_done_i,
  input  wire logic                      low_power_i,
  input  wire logic [DW-1:0]             upper_swing_i,
  input  wire logic [DW-1:0]             lower_swing_i,
  input  wire logic [pat_pkg::SENS_W-1:0] pos_sens_i,
  input  wire logic [pat_pkg::SENS_W-1:0] neg_sens_i,
  output logic      [STAGES-1:0]         proximity_o,
  output logic      [STAGES-1:0]         ambient_gate_o,
  output logic                           alert_o
);
  localparam int SW  = $clog2(STAGES);
  localparam int FD  = pat_pkg::FAST_DEPTH;
  localparam int HCW = pat_pkg::HOLD_CNT_W;
  localparam int RCW = pat_pkg::FP_RECAL_W;
  localparam int PW  = DW + pat_pkg::SENS_SHIFT;

  // configuration registers
  logic [DW-1:0] timing_ff;
  logic [DW-1:0] level_ff;
  logic [DW-1:0] recal_ff;

  // per-stage compensation memory
  logic [DW-1:0]  tap_ff   [STAGES][FD];
  logic [DW-1:0]  slow1_ff [STAGES];
  logic [DW-1:0]  amb_ff   [STAGES];
  logic [DW-1:0]  upper_ff [STAGES];
  logic [DW-1:0]  lower_ff [STAGES];
  logic [pat_pkg::DEC_W-1:0] dec_ff [STAGES];
  logic [HCW-1:0] hold_ff  [STAGES];
  logic [RCW-1:0] rcnt_ff  [STAGES];

  logic [STAGES-1:0] prox_ff;
  logic [STAGES-1:0] hover_ff;
  logic [STAGES-1:0] gate_ff;
  logic [STAGES-1:0] seed_ff;
  logic [STAGES-1:0] alarm_ff;
  logic [STAGES-1:0] pend_ff;
  wire  [STAGES-1:0] cal_off;

  // register fields
  wire [pat_pkg::DEC_W-1:0] decimator =
    timing_ff[pat_pkg::DEC_LSB +: pat_pkg::DEC_W];
  wire [pat_pkg::HOLD_W-1:0] fp_hold =
    timing_ff[pat_pkg::FP_HOLD_LSB +: pat_pkg::HOLD_W];
  wire [pat_pkg::HOLD_W-1:0] lp_hold =
    timing_ff[pat_pkg::LP_HOLD_LSB +: pat_pkg::HOLD_W];
  wire [pat_pkg::HOVER_W-1:0] hover_level =
    level_ff[pat_pkg::HOVER_LSB +: pat_pkg::HOVER_W];
  wire [pat_pkg::RATE_W-1:0] rate_level =
    level_ff[pat_pkg::RATE_LSB +: pat_pkg::RATE_W];
  wire [pat_pkg::UPD_W-1:0] ambient_update_level =
    level_ff[pat_pkg::UPD_LSB +: pat_pkg::UPD_W];
  wire [pat_pkg::FP_RECAL_W-1:0] fp_recal =
    recal_ff[pat_pkg::FP_RECAL_LSB +: pat_pkg::FP_RECAL_W];
  wire [pat_pkg::LP_RECAL_W-1:0] lp_recal =
    recal_ff[pat_pkg::LP_RECAL_LSB +: pat_pkg::LP_RECAL_W];

  // mode-dependent counts, in conversion sequences
  wire [HCW-1:0] hold_load = low_power_i
    ? HCW'({lp_hold, pat_pkg::LP_HOLD_SHIFT'(0)})     // [RULE18]
    : HCW'({fp_hold, pat_pkg::FP_HOLD_SHIFT'(0)});    // [RULE17]
  wire [RCW-1:0] recal_timeout = low_power_i ? RCW'(lp_recal) : fp_recal;

  // rate and hover levels scaled by 16 codes, update level unscaled
  wire [DW-1:0] rate_lim  = DW'({rate_level, pat_pkg::LEVEL_SHIFT'(0)});
  wire [DW-1:0] hover_lim = DW'({hover_level, pat_pkg::LEVEL_SHIFT'(0)});
  wire [DW-1:0] upd_lim   = DW'(ambient_update_level);

  // register access
  wire wr_timing = reg_wr_i & (reg_addr_i == pat_pkg::ADDR_TIMING);
  wire wr_level  = reg_wr_i & (reg_addr_i == pat_pkg::ADDR_LEVEL);
  wire wr_recal  = reg_wr_i & (reg_addr_i == pat_pkg::ADDR_RECAL);
  wire [DW-1:0] rd_mux =
    (reg_addr_i == pat_pkg::ADDR_TIMING) ? timing_ff :
    (reg_addr_i == pat_pkg::ADDR_LEVEL)  ? level_ff  :
    (reg_addr_i == pat_pkg::ADDR_RECAL)  ? recal_ff  : '0;

  // current sample, its stage record and the fast queue after a push
  wire [SW-1:0] st     = sample_stage_i;
  wire          seeded = seed_ff[st];
  wire          take   = sample_valid_i & seeded;
  wire [DW-1:0] old0   = tap_ff[st][0];
  wire [DW-1:0] old1   = tap_ff[st][1];
  wire [DW-1:0] old2   = tap_ff[st][2];
  wire [DW-1:0] amb    = amb_ff[st];
  wire [DW+1:0] sum4   = {2'b00, sample_data_i} + {2'b00, old0} +
                         {2'b00, old1} + {2'b00, old2};
  wire [DW-1:0] fast_avg = sum4[DW+1:2];

  // decimator: drop that many samples of the stage, then push one
  wire dec_hit = dec_ff[st] == decimator;              // [RULE6] [RULE7]
  wire push    = take & dec_hit;                       // [RULE20]

  logic approach_over;
  logic hover_over;
  logic slow_over;

  // after the push, tap 1 is the old tap 0 and tap 3 the old tap 2
  pat_diff_cmp #(
    .DW (DW)
  ) u_cmp_approach (
    .a_i     (old0),
    .b_i     (old2),
    .limit_i (rate_lim),
    .over_o  (approach_over)
  ); // [RULE2] [RULE4]

  pat_diff_cmp #(
    .DW (DW)
  ) u_cmp_hover (
    .a_i     (fast_avg),
    .b_i     (amb),
    .limit_i (hover_lim),
    .over_o  (hover_over)
  ); // [RULE3] [RULE5]

  // slow tap 0 is the newest result, slow tap 1 the last value accepted
  pat_diff_cmp #(
    .DW (DW)
  ) u_cmp_slow (
    .a_i     (sample_data_i),
    .b_i     (slow1_ff[st]),
    .limit_i (upd_lim),
    .over_o  (slow_over)
  ); // [RULE9]

  wire prox_new = approach_over | hover_over;               // [RULE1]
  wire prox_now = push ? prox_new : prox_ff[st];
  wire slow_pos = sample_data_i > slow1_ff[st];
  wire gate_new = slow_over & slow_pos & ~prox_now;         // [RULE9] [RULE10]

  // ambient moves on the first result, on a forced recal, or on an untouched, gated sample outside the hold-off
  wire amb_upd = take & gate_new & ~cal_off[st];     // [RULE10] [RULE11] [RULE12] [RULE21]
  wire force_recal = take & pend_ff[st];                    // [RULE19]
  wire [DW:0] amb_err = {1'b0, sample_data_i} - {1'b0, amb};
  wire [DW:0] amb_step = $signed(amb_err) >>> pat_pkg::AMB_SHIFT;
  wire [DW-1:0] amb_next =
    !seeded     ? sample_data_i :
    force_recal ? fast_avg :
    amb_upd     ? amb + amb_step[DW-1:0] : amb;
  wire amb_write = sample_valid_i & (!seeded | force_recal | amb_upd);

  // trip levels are a sensitivity share of the swing around the ambient
  wire [pat_pkg::SENS_SHIFT-1:0] pos_pct = pat_pkg::SENS_SHIFT'(
    pat_pkg::SENS_BASE + pat_pkg::SENS_STEP * int'(pos_sens_i));
  wire [pat_pkg::SENS_SHIFT-1:0] neg_pct = pat_pkg::SENS_SHIFT'(
    pat_pkg::SENS_BASE + pat_pkg::SENS_STEP * int'(neg_sens_i));
  wire [PW-1:0] pos_prod = PW'(upper_swing_i) * PW'(pos_pct);   // [RULE14]
  wire [PW-1:0] neg_prod = PW'(lower_swing_i) * PW'(neg_pct);   // [RULE14]
  wire [DW-1:0] upper_next = amb_next + pos_prod[PW-1:pat_pkg::SENS_SHIFT];
  wire [DW-1:0] lower_next = amb_next - neg_prod[PW-1:pat_pkg::SENS_SHIFT];

  wire crossed = (sample_data_i > upper_ff[st]) |
                 (sample_data_i < lower_ff[st]);                // [RULE15]

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      timing_ff   <= pat_pkg::TIMING_RST;
      level_ff    <= pat_pkg::LEVEL_RST;
      recal_ff    <= pat_pkg::RECAL_RST;
      reg_rdata_o <= '0;
    end else begin
      if (wr_timing) begin
        timing_ff <= reg_wdata_i;                               // [RULE8]
      end
      if (wr_level) begin
        level_ff <= reg_wdata_i;
      end
      if (wr_recal) begin
        recal_ff <= reg_wdata_i;
      end
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

  // stage record written for the stage whose sample is present
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      for (int s = 0; s < STAGES; s++) begin
        for (int k = 0; k < FD; k++) begin
          tap_ff[s][k] <= '0;
        end
        slow1_ff[s] <= '0;
        amb_ff[s]   <= '0;
        upper_ff[s] <= '0;
        lower_ff[s] <= '0;
        dec_ff[s]   <= '0;
      end
      prox_ff  <= '0;
      hover_ff <= '0;
      gate_ff  <= '0;
      seed_ff  <= '0;
      alarm_ff <= '0;
    end else if (sample_valid_i) begin
      seed_ff[st] <= 1'b1;
      if (!seeded) begin
        // first result after reset fills the queues and sets the ambient
        for (int k = 0; k < FD; k++) begin
          tap_ff[st][k] <= sample_data_i;
        end
        slow1_ff[st] <= sample_data_i;
        dec_ff[st]   <= '0;
      end else begin
        dec_ff[st] <= dec_hit ? '0 : dec_ff[st] + 1'b1;        // [RULE6]
        if (push) begin
          tap_ff[st][0] <= sample_data_i;
          for (int k = 1; k < FD; k++) begin
            tap_ff[st][k] <= tap_ff[st][k-1];
          end
          prox_ff[st]  <= prox_new;                              // [RULE1] [RULE20]
          hover_ff[st] <= hover_over;                            // [RULE3]
        end
        gate_ff[st]  <= gate_new;                                // [RULE9]
        alarm_ff[st] <= crossed;                                 // [RULE15]
        if (amb_upd) begin
          slow1_ff[st] <= sample_data_i;                         // [RULE10]
        end
      end
      if (amb_write) begin
        amb_ff[st]   <= amb_next;                                // [RULE16]
        upper_ff[st] <= upper_next;                              // [RULE13]
        lower_ff[st] <= lower_next;                              // [RULE13]
      end
    end
  end

  // per-stage hold-off and recalibration timers run on sequence ends
  for (genvar s = 0; s < STAGES; s++) begin : g_stage
    wire hovering = prox_ff[s] & hover_ff[s];
    wire [RCW-1:0] rcnt_inc = rcnt_ff[s] + 1'b1;
    wire recal_hit = seq_done_i & hovering & (recal_timeout != '0) &
                     (rcnt_inc >= recal_timeout);               // [RULE19]
    wire consumed = take & (st == SW'(s));

    assign cal_off[s] = prox_ff[s] | (hold_ff[s] != '0);        // [RULE17] [RULE18]

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
        hold_ff[s] <= '0;
        rcnt_ff[s] <= '0;
        pend_ff[s] <= 1'b0;
      end else begin
        // reloaded while proximity holds, so the count starts at its end
        if (prox_ff[s]) begin
          hold_ff[s] <= hold_load;                              // [RULE17] [RULE18]
        end else if (seq_done_i && hold_ff[s] != '0) begin
          hold_ff[s] <= hold_ff[s] - 1'b1;
        end
        if (!hovering || recal_hit) begin
          rcnt_ff[s] <= '0;
        end else if (seq_done_i) begin
          rcnt_ff[s] <= rcnt_inc;                               // [RULE19]
        end
        // a new timeout in the cycle of consumption keeps the request
        pend_ff[s] <= recal_hit | (pend_ff[s] & ~consumed);     // [RULE19] [RULE21]
      end
    end
  end

  assign proximity_o    = prox_ff;
  assign ambient_gate_o = gate_ff;
  assign alert_o        = |alarm_ff;                            // [RULE15]
endmodule
`default_nettype wire

// ===== sim/pat_tracker_props.sv
// port assertions for the proximity and ambient tracker
// assumes a bind onto pat_tracker, one clock domain, reset_i active high
`timescale 1ns/1ps
`default_nettype none
module pat_tracker_props #(
  parameter int STAGES = 8,
  parameter int DW     = 16
) (
  input wire logic                      clk_sys_i,
  input wire logic                      reset_i,
  input wire logic                      reg_rd_i,
  input wire logic [9:0]                reg_addr_i,
  input wire logic [DW-1:0]             reg_rdata_o,
  input wire logic                      sample_valid_i,
  input wire logic [$clog2(STAGES)-1:0] sample_stage_i,
  input wire logic [STAGES-1:0]         proximity_o,
  input wire logic [STAGES-1:0]         ambient_gate_o,
  input wire logic                      alert_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  quiet_release_a: assert property ($fell(reset_i) |-> proximity_o == '0 && !alert_o)
    else $error("outputs not quiet after reset");
  gate_excl_a: assert property ((ambient_gate_o & proximity_o) == '0)
    else $error("ambient gate open during proximity");
  prox_on_sample_a: assert property ($changed(proximity_o) |-> $past(sample_valid_i))
    else $error("proximity moved without a sample");
  prox_one_stage_a: assert property (((proximity_o ^ $past(proximity_o))
    & ~(STAGES'(1) << $past(sample_stage_i))) == '0)
    else $error("proximity moved on a foreign stage");
  gate_one_stage_a: assert property ($changed(ambient_gate_o) |-> $past(sample_valid_i)
    && ((ambient_gate_o ^ $past(ambient_gate_o)) & ~(STAGES'(1) << $past(sample_stage_i))) == '0)
    else $error("ambient gate moved on a foreign stage");
  alert_on_sample_a: assert property ($changed(alert_o) |-> $past(sample_valid_i))
    else $error("alert moved without a sample");
  rdata_hold_a: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_rd_i && reg_addr_i > 10'h004 |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ===== sim/pat_conv_model.sv
// converter model: delivers tagged stage results and end-of-sequence pulses
// assumes the bench calls its tasks; drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module pat_conv_model #(
  parameter int STAGES = 8,
  parameter int DW     = 16
) (
  input  wire logic                      clk_sys_i,
  output logic                           sample_valid_o,
  output logic [$clog2(STAGES)-1:0]      sample_stage_o,
  output logic [DW-1:0]                  sample_data_o,
  output logic                           seq_done_o
);
  initial begin
    sample_valid_o = 1'b0;
    sample_stage_o = '0;
    sample_data_o  = '0;
    seq_done_o     = 1'b0;
  end
  // burst of n results on one stage, closed by a sequence pulse
  task automatic burst(input logic [$clog2(STAGES)-1:0] st, input logic [DW-1:0] d, input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      sample_valid_o <= 1'b1;
      sample_stage_o <= st;
      sample_data_o  <= d;
      @(negedge clk_sys_i);
      sample_valid_o <= 1'b0;
      // idle bus shows garbage so a stale value never looks valid
      sample_data_o  <= ~d;
      sample_stage_o <= ~st;
    end
    seq_done_o <= 1'b1;
    @(negedge clk_sys_i);
    seq_done_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for pat_tracker
// assumes the converter model drives the sample path, bench drives registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int STAGES = pat_pkg::STAGES;
  localparam int DW     = pat_pkg::DW;
  logic                   clk_sys_i;
  logic                   reset_i;
  logic                   reg_wr_i;
  logic                   reg_rd_i;
  logic [pat_pkg::AW-1:0] reg_addr_i;
  logic [DW-1:0]          reg_wdata_i;
  logic [DW-1:0]          reg_rdata_o;
  logic                   sample_valid_i;
  logic [2:0]             sample_stage_i;
  logic [DW-1:0]          sample_data_i;
  logic                   seq_done_i;
  logic                   low_power_i;
  logic [3:0]             neg_sens_i;
  logic [STAGES-1:0]      proximity_o;
  logic [STAGES-1:0]      ambient_gate_o;
  logic                   alert_o;
  int                     err_total;
  int                     samples_checked;
  pat_conv_model u_pat_conv_model (.clk_sys_i(clk_sys_i), .sample_valid_o(sample_valid_i),
    .sample_stage_o(sample_stage_i), .sample_data_o(sample_data_i), .seq_done_o(seq_done_i));
  pat_tracker u_pat_tracker (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i), .sample_stage_i(sample_stage_i),
    .sample_data_i(sample_data_i), .seq_done_i(seq_done_i), .low_power_i(low_power_i),
    .upper_swing_i(16'h03e8), .lower_swing_i(16'h03e8), .pos_sens_i(4'h0),
    .neg_sens_i(neg_sens_i), .proximity_o(proximity_o), .ambient_gate_o(ambient_gate_o),
    .alert_o(alert_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [DW-1:0] d);
    @(negedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(negedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [DW-1:0] exp);
    @(negedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(negedge clk_sys_i);
    reg_rd_i <= 1'b0;
    check("reg_rdata_o", reg_rdata_o, exp);
  endtask
  task automatic do_reset();
    reset_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    reset_i = 1'b0;
  endtask
  initial begin
    err_total = 0;
    samples_checked = 0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    low_power_i = 1'b0;
    neg_sens_i = 4'h0;
    do_reset();
    rd(10'h002, 16'h0000);
    rd(10'h003, 16'h0000);
    wr(10'h003, 16'h3f04);
    rd(10'h003, 16'h3f04);
    wr(10'h005, 16'hffff);
    rd(10'h005, 16'h0000);
    wr(10'h002, 16'h0000);
    // hover: flat level, then a jump that the rate comparator cannot see
    u_pat_conv_model.burst(3'h0, 16'd1000, 4);
    check("prox0_flat", DW'(proximity_o[0]), 16'h0000);
    check("alert_flat", DW'(alert_o), 16'h0000);
    u_pat_conv_model.burst(3'h0, 16'd2000, 4);
    check("prox0_hover", DW'(proximity_o[0]), 16'h0001);
    check("gate0_frozen", DW'(ambient_gate_o[0]), 16'h0000);
    check("alert_upper", DW'(alert_o), 16'h0001);
    check("prox_others", DW'(proximity_o[7:1]), 16'h0000);
    // rate comparator: arrival on stage 1, departure on stage 2
    wr(10'h003, 16'h01ff);
    u_pat_conv_model.burst(3'h1, 16'd1000, 4);
    u_pat_conv_model.burst(3'h1, 16'd1100, 3);
    check("prox1_arrive", DW'(proximity_o[1]), 16'h0001);
    u_pat_conv_model.burst(3'h2, 16'd1000, 4);
    u_pat_conv_model.burst(3'h2, 16'd900, 3);
    check("prox2_leave", DW'(proximity_o[2]), 16'h0001);
    // decimator 15: sixteen samples per fast push
    u_pat_conv_model.burst(3'h3, 16'd1000, 1);
    wr(10'h002, 16'h000f);
    u_pat_conv_model.burst(3'h3, 16'd2000, 8);
    check("prox3_dropped", DW'(proximity_o[3]), 16'h0000);
    u_pat_conv_model.burst(3'h3, 16'd2000, 32);
    check("prox3_pushed", DW'(proximity_o[3]), 16'h0001);
    // slow path gate: update level 3 is a strict bound
    wr(10'h002, 16'h0000);
    wr(10'h003, 16'hffff);
    u_pat_conv_model.burst(3'h4, 16'd1000, 1);
    u_pat_conv_model.burst(3'h4, 16'd1003, 1);
    check("gate4_below", DW'(ambient_gate_o[4]), 16'h0000);
    u_pat_conv_model.burst(3'h4, 16'd1010, 1);
    check("gate4_open", DW'(ambient_gate_o[4]), 16'h0001);
    u_pat_conv_model.burst(3'h4, 16'd1010, 1);
    check("gate4_again", DW'(ambient_gate_o[4]), 16'h0000);
    // forced recal after two hovering sequences, then a 1 x 16 sequence hold-off
    wr(10'h002, 16'h0110);
    wr(10'h003, 16'h3f04);
    wr(10'h004, 16'h0002);
    rd(10'h004, 16'h0002);
    u_pat_conv_model.burst(3'h5, 16'd1000, 1);
    u_pat_conv_model.burst(3'h5, 16'd2000, 4);
    check("prox5_hover", DW'(proximity_o[5]), 16'h0001);
    repeat (3) u_pat_conv_model.burst(3'h5, 16'd2000, 1);
    check("prox5_recal", DW'(proximity_o[5]), 16'h0000);
    u_pat_conv_model.burst(3'h5, 16'd2040, 2);
    check("gate5_held", DW'(ambient_gate_o[5]), 16'h0001);
    repeat (16) u_pat_conv_model.burst(3'h7, 16'd1000, 1);
    u_pat_conv_model.burst(3'h5, 16'd2040, 2);
    check("gate5_free", DW'(ambient_gate_o[5]), 16'h0000);
    // low power hold-off is 1 x 4 sequences
    low_power_i <= 1'b1;
    u_pat_conv_model.burst(3'h6, 16'd1000, 1);
    u_pat_conv_model.burst(3'h6, 16'd2000, 1);
    check("prox6_set", DW'(proximity_o[6]), 16'h0001);
    u_pat_conv_model.burst(3'h6, 16'd1000, 4);
    check("prox6_clear", DW'(proximity_o[6]), 16'h0000);
    u_pat_conv_model.burst(3'h6, 16'd1040, 2);
    check("gate6_held", DW'(ambient_gate_o[6]), 16'h0001);
    repeat (4) u_pat_conv_model.burst(3'h7, 16'd1000, 1);
    u_pat_conv_model.burst(3'h6, 16'd1040, 2);
    check("gate6_free", DW'(ambient_gate_o[6]), 16'h0000);
    // second reset in mid-run clears flags and registers
    do_reset();
    check("prox_reset", DW'(proximity_o), 16'h0000);
    rd(10'h003, 16'h0000);
    // lower trip at code 8: ambient minus 40/64 of the swing
    neg_sens_i <= 4'h8;
    u_pat_conv_model.burst(3'h0, 16'd1000, 1);
    u_pat_conv_model.burst(3'h0, 16'd500, 1);
    check("alert_mid", DW'(alert_o), 16'h0000);
    u_pat_conv_model.burst(3'h0, 16'd300, 1);
    check("alert_lower", DW'(alert_o), 16'h0001);
    finish_test();
  end
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
endmodule
bind pat_tracker pat_tracker_props #(.STAGES(STAGES), .DW(DW)) u_pat_tracker_props (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i), .sample_stage_i(sample_stage_i),
  .proximity_o(proximity_o), .ambient_gate_o(ambient_gate_o), .alert_o(alert_o));
`default_nettype wire
